// >>> hdl/fdi_drive_if.v
// Operation
// RULE1 - sector counter advances on every second sector mark, counting 0 to 15
// RULE2 - index mark clears that drive's sector counter each revolution
// RULE3 - sector and index inputs sampled at execute phase before use
// RULE4 - sector count output muxed by current drive select
// RULE5 - three-drive mux: drive 0 versus 1, then result versus 2
// RULE6 - two or three drive build, one sector counter each
// RULE7 - with control gate, bit 6 steps in, bit 4 steps out
// RULE8 - control gate with bit 2 raises head-load strobe for selected drive
// RULE9 - optional head-loaded status bit, else software reloads head
// RULE10 - write clock: halve oscillator, decade count, decode two bit clocks
// RULE11 - two-drive build selects 10 MHz or 5 MHz time base
// RULE12 - read data and drive status taken only from selected drive
// RULE13 - write data, enable, unsafe reset go only to selected drive
// RULE14 - sector mark status set when a sector mark arrives
// RULE15 - certain status bits clocked at address-update phase
// RULE16 - byte ready after eight serial bits gathered or due
// RULE17 - ten millisecond access delay timer available
// RULE18 - execute phase is where the microinstruction takes effect
// RULE19 - strobes last one machine cycle, none without control gate
`timescale 1ns/1ps
`default_nettype none
`include "fdi_defs.vh"
module fdi_drive_if #(
  parameter NDRV       = 3,
  parameter HLD_STATUS = 1,
  parameter ACCESS_CYC = (`FDI_ACCESS_MS * `FDI_CLK_KHZ)
) (
  input  wire                  clk,
  input  wire                  rstn,
  input  wire                  execute_phase,
  input  wire                  address_update_phase,
  input  wire [15:0]           microword_bits,
  input  wire                  mechanical_control_gate,
  input  wire [1:0]            drive_sel,
  input  wire                  osc_10mhz,
  input  wire                  time_base_full,
  input  wire [NDRV-1:0]       sector_mark_pulse,
  input  wire [NDRV-1:0]       index_mark,
  input  wire [NDRV-1:0]       read_data_in,
  input  wire [NDRV-1:0]       track_zero_in,
  input  wire [NDRV-1:0]       file_ready_in,
  input  wire [NDRV-1:0]       read_clock_in,
  input  wire [NDRV-1:0]       head_loaded_in,
  input  wire                  write_data,
  input  wire                  write_enable,
  input  wire                  file_unsafe_reset,
  input  wire                  serial_bit,
  input  wire                  sector_status_clear,
  input  wire                  access_start,
  output reg  [`FDI_SCT_W-1:0] sector_count_bits,
  output reg                   sector_mark_status,
  output reg                   head_loaded_status,
  output reg                   byte_ready_status,
  output reg                   track_zero_flag,
  output reg                   read_data,
  output reg                   file_ready,
  output reg                   read_clock,
  output reg  [NDRV-1:0]       step_in,
  output reg  [NDRV-1:0]       step_out,
  output reg  [NDRV-1:0]       head_load_strobe,
  output reg  [NDRV-1:0]       drv_write_data,
  output reg  [NDRV-1:0]       drv_write_enable,
  output reg  [NDRV-1:0]       drv_unsafe_reset,
  output reg                   write_bit_timing_a,
  output reg                   write_bit_timing_b,
  output reg                   time_base,
  output reg                   access_delay
);

  // two-stage selection of one bit per drive
  function sel_bit;
    input [2:0] v;
    input [1:0] s;
    reg         first;
    begin
      first = (s == `FDI_DRV1) ? v[1] : v[0];
      sel_bit = (s == `FDI_DRV2) ? v[2] : first;
    end
  endfunction

  // one-hot mask of the selected drive
  function [NDRV-1:0] drv_mask;
    input [1:0] s;
    integer     k;
    begin
      drv_mask = {NDRV{1'b0}};
      for (k = 0; k < NDRV; k = k + 1) begin
        if (s == k[1:0]) drv_mask[k] = 1'b1;
      end
    end
  endfunction

  localparam NIN = 7;
  wire [NIN*NDRV-1:0] pin_vec = {head_loaded_in, read_clock_in, file_ready_in,
                                 track_zero_in, read_data_in, index_mark,
                                 sector_mark_pulse};

  // three-flop synchronisers on all drive pins plus oscillator
  reg [NIN*NDRV:0] sync1;
  reg [NIN*NDRV:0] sync2;
  reg [NIN*NDRV:0] sync3;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= {(NIN*NDRV+1){1'b0}};
      sync2 <= {(NIN*NDRV+1){1'b0}};
      sync3 <= {(NIN*NDRV+1){1'b0}};
    end else begin
      sync1 <= {osc_10mhz, pin_vec};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // filtered levels: change only when stages two and three agree
  reg [NIN*NDRV:0] pin_lvl;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_lvl <= {(NIN*NDRV+1){1'b0}};
    end else begin
      pin_lvl <= (sync2 & sync3) | (pin_lvl & (sync2 | sync3));
    end
  end

  wire [NDRV-1:0] scm_l = pin_lvl[NDRV-1:0];
  wire [NDRV-1:0] idx_l = pin_lvl[2*NDRV-1:NDRV];
  wire [2:0] rd_v  = pin_lvl[3*NDRV-1:2*NDRV];
  wire [2:0] tk_v  = pin_lvl[4*NDRV-1:3*NDRV];
  wire [2:0] fr_v  = pin_lvl[5*NDRV-1:4*NDRV];
  wire [2:0] rc_v  = pin_lvl[6*NDRV-1:5*NDRV];
  wire [2:0] hl_v  = pin_lvl[7*NDRV-1:6*NDRV];
  wire       osc_l = pin_lvl[NIN*NDRV];

  // per-drive sector counters, sampled at execute phase
  reg [NDRV-1:0]       scm_smp;
  reg [NDRV-1:0]       idx_smp;
  reg [NDRV-1:0]       half;
  reg [`FDI_SCT_W-1:0] sct [0:NDRV-1];
  reg                  scm_event;
  integer              d;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scm_smp   <= {NDRV{1'b0}};
      idx_smp   <= {NDRV{1'b0}};
      half      <= {NDRV{1'b0}};
      scm_event <= 1'b0;
      for (d = 0; d < NDRV; d = d + 1) sct[d] <= `FDI_SCT_ZERO;
    end else begin
      scm_event <= 1'b0;
      if (execute_phase) begin
        scm_smp <= scm_l; // RULE3
        idx_smp <= idx_l; // RULE3
        for (d = 0; d < NDRV; d = d + 1) begin // RULE6
          if (idx_l[d] && !idx_smp[d]) begin
            sct[d]  <= `FDI_SCT_ZERO; // RULE2
            half[d] <= 1'b0;
          end else if (scm_l[d] && !scm_smp[d]) begin
            half[d] <= ~half[d];
            if (half[d]) sct[d] <= sct[d] + 4'h1; // RULE1
          end
        end
        if (|(scm_l & ~scm_smp & drv_mask(drive_sel))) scm_event <= 1'b1;
      end
    end
  end

  // count of selected drive, two-stage in three-drive build
  wire [2:0] cnt_b0 = {sct[NDRV-1][0], sct[1][0], sct[0][0]};
  wire [2:0] cnt_b1 = {sct[NDRV-1][1], sct[1][1], sct[0][1]};
  wire [2:0] cnt_b2 = {sct[NDRV-1][2], sct[1][2], sct[0][2]};
  wire [2:0] cnt_b3 = {sct[NDRV-1][3], sct[1][3], sct[0][3]};
  wire [1:0] sel_eff = (NDRV == 3) ? drive_sel : {1'b0, drive_sel[0]};

  // selected-drive status and mux outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sector_count_bits <= `FDI_SCT_ZERO;
      track_zero_flag   <= 1'b0;
      read_data         <= 1'b0;
      file_ready        <= 1'b0;
      read_clock        <= 1'b0;
      drv_write_data    <= {NDRV{1'b0}};
      drv_write_enable  <= {NDRV{1'b0}};
      drv_unsafe_reset  <= {NDRV{1'b0}};
    end else begin
      sector_count_bits <= {sel_bit(cnt_b3, sel_eff), sel_bit(cnt_b2, sel_eff),
                            sel_bit(cnt_b1, sel_eff), sel_bit(cnt_b0, sel_eff)}; // RULE4 RULE5
      read_data         <= sel_bit(rd_v, sel_eff); // RULE12
      file_ready        <= sel_bit(fr_v, sel_eff); // RULE12
      read_clock        <= sel_bit(rc_v, sel_eff); // RULE12
      track_zero_flag   <= sel_bit(tk_v, sel_eff); // RULE12
      drv_write_data    <= drv_mask(drive_sel) & {NDRV{write_data}}; // RULE13
      drv_write_enable  <= drv_mask(drive_sel) & {NDRV{write_enable}}; // RULE13
      drv_unsafe_reset  <= drv_mask(drive_sel) & {NDRV{file_unsafe_reset}}; // RULE13
    end
  end

  // status bits latched at address-update phase; set beats clear
  reg scm_pend;
  reg bits_due;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scm_pend           <= 1'b0;
      sector_mark_status <= 1'b0;
      head_loaded_status <= 1'b0;
      byte_ready_status  <= 1'b0;
    end else begin
      if (scm_event) begin
        scm_pend <= 1'b1; // RULE14
      end else if (address_update_phase) begin
        scm_pend <= 1'b0;
      end
      if (address_update_phase) begin
        if (scm_pend || scm_event) begin
          sector_mark_status <= 1'b1; // RULE14 RULE15
        end else if (sector_status_clear) begin
          sector_mark_status <= 1'b0;
        end
        head_loaded_status <= (HLD_STATUS != 0) && sel_bit(hl_v, sel_eff); // RULE9 RULE15
        byte_ready_status  <= bits_due; // RULE16 RULE15
      end
    end
  end

  // serial bit count, byte due on eighth bit
  reg [2:0] bit_cnt;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt  <= `FDI_BITS_ZERO;
      bits_due <= 1'b0;
    end else begin
      if (serial_bit) begin
        bit_cnt  <= bit_cnt + 3'h1;
        bits_due <= (bit_cnt == `FDI_BITS_LAST); // RULE16
      end else if (address_update_phase) begin
        bits_due <= 1'b0;
      end
    end
  end

  // step and head-load strobes at execute phase, one machine cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_in          <= {NDRV{1'b0}};
      step_out         <= {NDRV{1'b0}};
      head_load_strobe <= {NDRV{1'b0}};
    end else if (execute_phase) begin // RULE18
      step_in          <= drv_mask(drive_sel) & {NDRV{mechanical_control_gate &
                          microword_bits[`FDI_UW_STEP_IN]}}; // RULE7 RULE19
      step_out         <= drv_mask(drive_sel) & {NDRV{mechanical_control_gate &
                          microword_bits[`FDI_UW_STEP_OUT]}}; // RULE7 RULE19
      head_load_strobe <= drv_mask(drive_sel) & {NDRV{mechanical_control_gate &
                          microword_bits[`FDI_UW_HEAD_LOAD]}}; // RULE8 RULE19
    end
  end

  // write clock: halve oscillator, decade count, decode
  reg       osc_q;
  reg       half_osc;
  reg [3:0] bcd;
  wire      osc_rise = osc_l && !osc_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_q              <= 1'b0;
      half_osc           <= 1'b0;
      bcd                <= `FDI_BCD_ZERO;
      time_base          <= 1'b0;
      write_bit_timing_a <= 1'b0;
      write_bit_timing_b <= 1'b0;
    end else begin
      osc_q <= osc_l;
      if (osc_rise) begin
        half_osc <= ~half_osc; // RULE10
        if (half_osc) begin
          bcd <= (bcd == `FDI_BCD_LAST) ? `FDI_BCD_ZERO : bcd + 4'h1; // RULE10
        end
      end
      time_base <= (NDRV == 2 && !time_base_full) ? half_osc : osc_l; // RULE11
      write_bit_timing_a <= (bcd == `FDI_WCLK_A_CNT); // RULE10
      write_bit_timing_b <= (bcd == `FDI_WCLK_B_CNT); // RULE10
    end
  end

  // ten millisecond access delay
  reg [31:0] acc_cnt;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_cnt      <= 32'h0;
      access_delay <= 1'b0;
    end else if (access_start) begin
      acc_cnt      <= ACCESS_CYC; // RULE17
      access_delay <= 1'b1;
    end else if (acc_cnt != 32'h0) begin
      acc_cnt      <= acc_cnt - 32'h1;
      access_delay <= (acc_cnt != 32'h1);
    end
  end

endmodule // fdi_drive_if
`default_nettype wire

// >>> hdl/fdi_defs.vh
`ifndef FDI_DEFS_VH
`define FDI_DEFS_VH
// microword bit positions
`define FDI_UW_STEP_IN   6
`define FDI_UW_STEP_OUT  4
`define FDI_UW_HEAD_LOAD 2
// sector counter
`define FDI_SCT_W        4
`define FDI_SCT_ZERO     4'h0
// access delay
`define FDI_ACCESS_MS    10
`define FDI_CLK_KHZ      125000
// bcd write-clock counter
`define FDI_BCD_LAST     4'h9
`define FDI_BCD_ZERO     4'h0
`define FDI_WCLK_A_CNT   4'h0
`define FDI_WCLK_B_CNT   4'h5
// drive select codes
`define FDI_DRV0         2'h0
`define FDI_DRV1         2'h1
`define FDI_DRV2         2'h2
// serial bits per byte
`define FDI_BITS_LAST    3'h7
`define FDI_BITS_ZERO    3'h0
`endif

// >>> dv/fdi_drive_if_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fdi_drive_if_chk #(parameter NDRV = 3) (
  input wire logic            clk,
  input wire logic            rstn,
  input wire logic            execute_phase,
  input wire logic            address_update_phase,
  input wire logic [15:0]     microword_bits,
  input wire logic            mechanical_control_gate,
  input wire logic [1:0]      drive_sel,
  input wire logic            write_enable,
  input wire logic [3:0]      sector_count_bits,
  input wire logic            sector_mark_status,
  input wire logic            byte_ready_status,
  input wire logic [NDRV-1:0] step_in,
  input wire logic [NDRV-1:0] head_load_strobe,
  input wire logic [NDRV-1:0] drv_write_enable,
  input wire logic            write_bit_timing_a,
  input wire logic            write_bit_timing_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // gated microword cycle
  sequence s_fire;
    execute_phase && mechanical_control_gate;
  endsequence
  // strobes go to the selected drive only
  property p_step_in;
    s_fire |=> step_in == ($past(microword_bits[6]) ? NDRV'(1) << $past(drive_sel) : '0);
  endproperty
  a_step_in: assert property (p_step_in) else $error("step in");
  property p_head_load;
    s_fire |=> head_load_strobe == ($past(microword_bits[2]) ? NDRV'(1) << $past(drive_sel) : '0);
  endproperty
  a_head_load: assert property (p_head_load) else $error("head load");
  property p_no_gate;
    execute_phase && !mechanical_control_gate |=> {step_in, head_load_strobe} == '0;
  endproperty
  a_no_gate: assert property (p_no_gate) else $error("strobe without gate");
  property p_hold;
    !execute_phase |=> $stable({step_in, head_load_strobe});
  endproperty
  a_hold: assert property (p_hold) else $error("strobe moved");
  // write enable routed by select
  property p_wr_route;
    $stable(drive_sel) && write_enable |=> drv_write_enable == NDRV'(1) << $past(drive_sel);
  endproperty
  a_wr_route: assert property (p_wr_route) else $error("write route");
  // count moves by one or clears
  property p_sct_step;
    $stable(drive_sel) [*4] ##0 $changed(sector_count_bits) |->
      sector_count_bits == $past(sector_count_bits) + 4'h1 || sector_count_bits == 4'h0;
  endproperty
  a_sct_step: assert property (p_sct_step) else $error("count jump");
  property p_status_phase;
    $changed({sector_mark_status, byte_ready_status}) |-> $past(address_update_phase);
  endproperty
  a_status_phase: assert property (p_status_phase) else $error("status off phase");
  property p_wclk_excl;
    !(write_bit_timing_a && write_bit_timing_b);
  endproperty
  a_wclk_excl: assert property (p_wclk_excl) else $error("write clocks overlap");
endmodule // fdi_drive_if_chk
bind fdi_drive_if fdi_drive_if_chk #(.NDRV(NDRV)) u_chk (.*);
`default_nettype wire

// >>> dv/fdi_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdi_drive_model #(parameter NDRV = 3) (
  input  wire logic            clk,
  input  wire logic [NDRV-1:0] step_in,
  input  wire logic [NDRV-1:0] step_out,
  input  wire logic [NDRV-1:0] head_load_strobe,
  output var  logic [NDRV-1:0] sector_mark_pulse,
  output var  logic [NDRV-1:0] index_mark,
  output var  logic [NDRV-1:0] track_zero_in,
  output var  logic [NDRV-1:0] head_loaded_in
);
  // drives idle at track zero, heads unloaded
  initial begin
    sector_mark_pulse = '0;
    index_mark = '0;
    track_zero_in = '1;
    head_loaded_in = '0;
  end
  // step in leaves track zero, step out returns
  always @(posedge clk) begin
    track_zero_in <= (track_zero_in | step_out) & ~step_in;
    head_loaded_in <= head_loaded_in | head_load_strobe;
  end
  // pulse long enough to span an execute phase
  task pulse(input int d, input bit idx);
    if (idx)
      index_mark[d] <= 1'b1;
    else
      sector_mark_pulse[d] <= 1'b1;
    repeat (12) @(posedge clk);
    index_mark[d] <= 1'b0;
    sector_mark_pulse[d] <= 1'b0;
  endtask
endmodule // fdi_drive_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rstn = 1'b0, execute_phase = 1'b0, address_update_phase = 1'b0;
  logic mechanical_control_gate = 1'b0, osc_10mhz = 1'b0, time_base_full = 1'b1;
  logic write_data = 1'b1, write_enable = 1'b1, file_unsafe_reset = 1'b0;
  logic serial_bit = 1'b0, sector_status_clear = 1'b0, access_start = 1'b0;
  logic [15:0] microword_bits = 16'h0000;
  logic [1:0]  drive_sel = 2'h0;
  logic [2:0]  read_data_in = 3'h0;
  wire  [2:0]  file_ready_in = ~read_data_in;
  wire  [2:0]  read_clock_in = read_data_in;
  logic [2:0]  sector_mark_pulse, index_mark, track_zero_in, head_loaded_in;
  logic [2:0]  step_in, step_out, head_load_strobe, drv_write_data, drv_write_enable;
  logic [2:0]  drv_unsafe_reset;
  logic [3:0]  sector_count_bits;
  logic        sector_mark_status, head_loaded_status, byte_ready_status, track_zero_flag;
  logic        read_data, file_ready, read_clock, write_bit_timing_a, write_bit_timing_b;
  logic        time_base, access_delay;
  logic [17:0] r;
  int          n_fail = 0, check_count = 0, ph = 0, na = 0, nb = 0, nt = 0;
  // select, gate, bits 6/4/2, read pins; then step in, step out, head load
  logic [17:0] rows [6] = '{
    18'b00_1_100_001_001_000_000, 18'b01_1_010_001_000_010_000,
    18'b10_1_001_100_000_000_100, 18'b10_0_111_011_000_000_000,
    18'b01_1_111_010_010_010_010, 18'b00_1_000_110_000_000_000};
  fdi_drive_if #(.NDRV(3), .ACCESS_CYC(50)) dut (.*);
  fdi_drive_model #(.NDRV(3)) drv (.*);
  always #4 clk = ~clk;
  initial #13 forever #50 osc_10mhz = ~osc_10mhz;
  always @(posedge write_bit_timing_a) na++;
  always @(posedge write_bit_timing_b) nb++;
  always @(posedge time_base) nt++;
  // machine cycle of eight clocks
  always @(posedge clk) begin
    ph <= ph + 1;
    execute_phase <= (ph % 8 == 2);
    address_update_phase <= (ph % 8 == 6);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic mark(input int d, input bit idx, input int n);
    repeat (n) begin
      drv.pulse(d, idx);
      repeat (12) @(posedge clk);
    end
  endtask
  task automatic bits(input int n);
    repeat (n) begin
      @(posedge clk) serial_bit <= 1'b1;
      @(posedge clk) serial_bit <= 1'b0;
      // return on the edge that latches the status
      @(posedge clk iff address_update_phase);
    end
  endtask
  // watchdog
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    bits(7);
    #1 chk(byte_ready_status, 1'b0);
    bits(1);
    #1 chk(byte_ready_status, 1'b1);
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk iff address_update_phase);
      drive_sel <= r[17:16];
      mechanical_control_gate <= r[15];
      microword_bits <= {9'h000, r[14], 1'b0, r[13], 1'b0, r[12], 2'h0};
      read_data_in <= r[11:9];
      write_enable <= r[15];
      file_unsafe_reset <= !r[15];
      @(posedge clk iff execute_phase);
      @(posedge clk iff address_update_phase);
      #1;
      chk(step_in, r[8:6]);
      chk(step_out, r[5:3]);
      chk(head_load_strobe, r[2:0]);
      chk(read_data, r[9 + r[17:16]]);
      chk(file_ready, !r[9 + r[17:16]]);
      chk(read_clock, r[9 + r[17:16]]);
      chk(drv_write_data, 3'h1 << r[17:16]);
      chk(drv_write_enable, r[15] ? 3'h1 << r[17:16] : 3'h0);
      chk(drv_unsafe_reset, r[15] ? 3'h0 : 3'h1 << r[17:16]);
    end
    repeat (8) @(posedge clk);
    chk(track_zero_flag, 1'b0);
    drive_sel <= 2'h2;
    mark(2, 1, 1);
    chk(head_loaded_status, 1'b1);
    chk(track_zero_flag, 1'b1);
    mark(2, 0, 1);
    chk(sector_count_bits, 4'h0);
    chk(sector_mark_status, 1'b1);
    mark(2, 0, 30);
    chk(sector_count_bits, 4'hF);
    mark(2, 0, 5);
    mark(0, 0, 2);
    chk(sector_count_bits, 4'h2);
    drive_sel <= 2'h0;
    repeat (6) @(posedge clk);
    chk(sector_count_bits, 4'h1);
    drive_sel <= 2'h2;
    mark(2, 1, 1);
    chk(sector_count_bits, 4'h0);
    sector_status_clear <= 1'b1;
    repeat (10) @(posedge clk);
    sector_status_clear <= 1'b0;
    chk(sector_mark_status, 1'b0);
    access_start <= 1'b1;
    @(posedge clk) access_start <= 1'b0;
    repeat (10) @(posedge clk);
    chk(access_delay, 1'b1);
    repeat (50) @(posedge clk);
    chk(access_delay, 1'b0);
    na = 0;
    nb = 0;
    nt = 0;
    repeat (2500) @(posedge clk);
    chk(na > 8 && na < 12, 1'b1);
    chk(nb > 8 && nb < 12, 1'b1);
    chk(nt > 195 && nt < 205, 1'b1);
    finish_test();
  end
endmodule // tb
`default_nettype wire
